// ### testbench/sac_approximation_register_asserts.sv
// port checker for the approximation register; full-word checks skip the feed-forward build
// assumes one clock domain and sight of the top module's ports only
`timescale 1ns/1ps
`default_nettype none

module sac_approximation_register_asserts #(
  parameter int WIDTH        = 8,
  parameter bit FEED_FORWARD = 1'b0
) (
  input wire logic             sys_clk,          // clock
  input wire logic             rst_n,            // reset, active low
  input wire logic             start_conversion, // start level
  input wire logic             master_clear,     // clear level
  input wire logic [WIDTH-1:0] result_bits,      // parallel result
  input wire logic             conv_done,        // done flag
  input wire logic             serial_out,       // serial result
  input wire logic [WIDTH-1:0] word_data,        // fifo head
  input wire logic             word_valid        // fifo head valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // a rise with clear low and an empty fifo launches a run; full fifo refuses
  sequence go_s;
    $rose(start_conversion) && !master_clear && !word_valid;
  endsequence
  // first three trial patterns, msb first
  sequence walk_s;
    result_bits == 8'h80 ##1 result_bits[6:0] == 7'h40 ##1 result_bits[5:0] == 6'h20;
  endsequence

  start_trial_a: assert property (disable iff (!rst_n || master_clear) go_s |=> walk_s)
    else $error("trial bits did not walk from the msb");
  bit_hold_a: assert property (disable iff (!rst_n || master_clear)
    go_s |=> ##2 $stable(result_bits[7]) [*7]) else $error("decided msb moved");
  done_timing_a: assert property (disable iff (!rst_n || master_clear || FEED_FORWARD)
    go_s |=> !conv_done [*8] ##1 conv_done) else $error("done flag not after eight decisions");
  serial_msb_a: assert property (go_s |=> !serial_out ##1 serial_out == result_bits[7])
    else $error("serial output wrong at start of run");
  serial_lsb_a: assert property (disable iff (!rst_n || FEED_FORWARD)
    $rose(conv_done) |-> serial_out == result_bits[0] ##1 !serial_out)
    else $error("serial output wrong around done");
  clear_zero_a: assert property (!FEED_FORWARD && master_clear
    |=> result_bits == '0 && !serial_out && !conv_done)
    else $error("clear did not zero the outputs");
  stay_clear_a: assert property (!master_clear && !start_conversion && result_bits == '0
    |=> result_bits == '0) else $error("cleared device left its state without start");
  word_push_a: assert property ($rose(conv_done) && !$past(word_valid)
    |-> word_valid && word_data == result_bits) else $error("finished word not queued");
  ff_serial_hold_a: assert property (FEED_FORWARD && $rose(conv_done) && !start_conversion
    |=> $stable(serial_out) ##1 !serial_out) else $error("feed-forward serial hold wrong");
endmodule

bind sac_approximation_register sac_approximation_register_asserts
  #(.WIDTH(WIDTH), .FEED_FORWARD(FEED_FORWARD)) sac_chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .start_conversion(start_conversion),
  .master_clear(master_clear), .result_bits(result_bits), .conv_done(conv_done),
  .serial_out(serial_out), .word_data(word_data), .word_valid(word_valid));
`default_nettype wire

// ### testbench/sac_approximation_register_tb.sv
// self-checking bench for the approximation register, both builds side by side
// assumes the comparator model and the bound port checker
`timescale 1ns/1ps
`default_nettype none

module sac_approximation_register_tb;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start_conversion = 1'b0;
  logic       master_clear = 1'b0;
  logic       word_ready = 1'b0;
  logic [7:0] level = 8'h00;
  logic       length_truncate, comp_decision, conv_done, serial_out, word_valid;
  logic [7:0] result_bits, word_data;
  logic       ff_start = 1'b0;
  logic       ff_trunc, ff_comp, ff_done, ff_serial, ff_word_valid;
  logic [7:0] ff_result, ff_word_data;
  logic [7:0] lv [6] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h80, 8'h01};
  int         n_errors = 0;
  int         compares = 0;
  int         cycles = 0;

  always #4 sys_clk = ~sys_clk;

  sac_approximation_register #(.FEED_FORWARD(1'b0)) sac_approximation_register_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .start_conversion(start_conversion),
    .master_clear(master_clear), .length_truncate(length_truncate),
    .comp_decision(comp_decision), .result_bits(result_bits), .conv_done(conv_done),
    .serial_out(serial_out), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready));
  sac_comparator_model sac_comparator_model_inst (.result_bits(result_bits),
    .analog_level(level), .comp_decision(comp_decision), .length_truncate(length_truncate));
  // feed-forward build shares clear and reader; clear must leave it alone
  sac_approximation_register #(.FEED_FORWARD(1'b1)) sac_approximation_register_ff_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .start_conversion(ff_start),
    .master_clear(master_clear), .length_truncate(ff_trunc),
    .comp_decision(ff_comp), .result_bits(ff_result), .conv_done(ff_done),
    .serial_out(ff_serial), .word_data(ff_word_data), .word_valid(ff_word_valid),
    .word_ready(word_ready));
  sac_comparator_model sac_comparator_model_ff_inst (.result_bits(ff_result),
    .analog_level(level), .comp_decision(ff_comp), .length_truncate(ff_trunc));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard: every test together needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  // feed-forward build cut to seven bits by the model; word checks ignore bits 1 and 0
  task automatic t_trunc(input logic [7:0] tgt);
    logic [7:0] sbits;
    sbits = 8'h00;
    @(posedge sys_clk);
    level <= tgt;
    ff_start <= 1'b1;
    @(posedge sys_clk);
    ff_start <= 1'b0;
    @(negedge sys_clk);
    chk("ff serial first", 8'h00, 8'(ff_serial));
    for (int k = 7; k >= 2; k--) begin
      @(negedge sys_clk);
      sbits[k] = ff_serial;
    end
    chk("ff done early", 8'h00, 8'(ff_done));
    repeat (2) @(negedge sys_clk);
    chk("ff done", 8'h01, 8'(ff_done));
    chk("ff serial held", 8'(tgt[1]), 8'(ff_serial));
    chk("ff short word", tgt & 8'hfc, ff_result & 8'hfc);
    chk("ff serial word", tgt & 8'hfc, sbits);
    chk("ff queued word", tgt & 8'hfc, ff_word_data & 8'hfc);
    @(negedge sys_clk);
    chk("ff serial off", 8'h00, 8'(ff_serial));
    $display("test truncate %h done", tgt);
  endtask

  // strobed run; outputs are sampled at negedges, clear of the posedge updates
  task automatic t_convert(input logic [7:0] tgt);
    logic [7:0] sbits;
    @(posedge sys_clk);
    level <= tgt;
    start_conversion <= 1'b1;
    @(posedge sys_clk);
    start_conversion <= 1'b0; // pulse shorter than a run
    @(negedge sys_clk);
    chk("serial first", 8'h00, 8'(serial_out));
    for (int k = 7; k >= 0; k--) begin
      @(negedge sys_clk);
      sbits[k] = serial_out;
    end
    chk("parallel word", tgt, result_bits);
    chk("serial word", tgt, sbits);
    repeat (2) @(negedge sys_clk);
    chk("done flag", 8'h01, 8'(conv_done));
    chk("serial after", 8'h00, 8'(serial_out));
    chk("held word", tgt, result_bits);
    chk("queued word", tgt, word_data);
    @(posedge sys_clk);
    word_ready <= 1'b1;
    @(posedge sys_clk);
    word_ready <= 1'b0;
    @(negedge sys_clk);
    chk("fifo empty", 8'h00, 8'(word_valid));
    $display("test convert %h done", tgt);
  endtask

  // clear in mid-run with start still high: clear wins, nothing is queued
  task automatic t_clear;
    @(posedge sys_clk);
    level <= 8'hff;
    start_conversion <= 1'b1;
    repeat (3) @(posedge sys_clk);
    master_clear <= 1'b1;
    @(posedge sys_clk);
    master_clear <= 1'b0;
    start_conversion <= 1'b0; // released low: device rests cleared
    repeat (5) @(negedge sys_clk);
    chk("cleared word", 8'h00, result_bits);
    chk("cleared serial", 8'h00, 8'(serial_out));
    chk("cleared done", 8'h00, 8'(conv_done));
    chk("partial dropped", 8'h00, 8'(word_valid));
    chk("ff ignores clear", 8'hb4, ff_result & 8'hfc);
    $display("test clear done");
  endtask

  // held start recycles with the reader stalled until the fifo refuses
  task automatic t_fill;
    int n;
    n = 0;
    @(posedge sys_clk);
    level <= 8'h3c;
    start_conversion <= 1'b1;
    repeat (180) @(posedge sys_clk); // held start recycles until the fifo holds 16 words
    start_conversion <= 1'b0;
    word_ready <= 1'b1;
    @(negedge sys_clk);
    while (word_valid === 1'b1 && n < 20) begin
      chk("drained word", 8'h3c, word_data);
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    word_ready <= 1'b0;
    chk("words held", 8'd16, 8'(n));
    $display("test fill done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset word", 8'h00, result_bits);
    chk("reset done", 8'h00, 8'(conv_done));
    $display("test reset done");
    t_trunc(8'hb7);
    foreach (lv[i]) t_convert(lv[i]);
    t_clear();
    t_convert(8'h69);
    t_fill();
    end_sim();
  end
endmodule
`default_nettype wire

// ### testbench/sac_comparator_model.sv
// comparator and dac pair at the far side of the approximation register
// assumes result_bits drives the dac directly, one step per code
`timescale 1ns/1ps
`default_nettype none

module sac_comparator_model (
  input  wire logic [7:0] result_bits,    // dac code
  input  wire logic [7:0] analog_level,   // input level in dac steps
  output logic            comp_decision,  // 1 keeps the trial bit
  output logic            length_truncate // early end request
);
  // ideal comparator: no offset, so a full eight-bit run must end on analog_level
  assign comp_decision   = (analog_level >= result_bits);
  // bit 1 cuts a feed-forward build to seven bits; the master-clear build must ignore it
  assign length_truncate = result_bits[1];
endmodule
`default_nettype wire

// ### verilog/sac_approximation_register.sv
// successive approximation sequencer with serial and parallel result
// assumes a comparator on comp_decision and a dac reading result_bits
// all inputs but rst_n are synchronous to sys_clk; conv_done moves on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_approximation_register #(
  parameter int WIDTH        = `SAC_WIDTH,      // at most eight bits per register
  parameter int FIFO_DEPTH   = `SAC_FIFO_DEPTH, // finished words held for the reader
  parameter bit FEED_FORWARD = 1'b0             // 0: master-clear variant, 1: feed-forward
) (
  input  wire logic             sys_clk,          // system clock, 125 MHz
  input  wire logic             rst_n,            // async reset, active low
  input  wire logic             start_conversion, // start request level
  input  wire logic             master_clear,     // clear, master-clear variant only
  input  wire logic             length_truncate,  // early end, feed-forward variant only
  input  wire logic             comp_decision,    // comparator: 1 keeps the trial bit
  output logic      [WIDTH-1:0] result_bits,      // parallel result to the dac
  output logic                  conv_done,        // conversion finished
  output logic                  serial_out,       // serial result, msb first
  output logic      [WIDTH-1:0] word_data,        // finished word at fifo head
  output logic                  word_valid,       // word_data holds a word
  input  wire logic             word_ready        // reader takes word_data
);

  localparam int BW = (WIDTH > 1) ? $clog2(WIDTH) : 1;

  // sequencer state
  sac_pkg::sac_state_t state_q;
  sac_pkg::sac_state_t state_d;
  logic [BW-1:0]       bit_q;
  logic [BW-1:0]       bit_d;
  logic [WIDTH-1:0]    result_q;
  logic [WIDTH-1:0]    result_d;
  logic                serial_q;
  logic                serial_d;
  logic                fin_q;
  logic                fin_d;
  logic                done_q;
  logic                done_d;

  // glue between sequencer, edge detector and fifo
  logic             start_rise;
  logic             push;
  logic [WIDTH-1:0] push_data;
  logic             fifo_ready;
  logic             clear;
  logic             go;
  logic             last;

  // start is recognised by its sampled rise
  sac_rise_detect u_start_rise (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .level_in (start_conversion),
    .rise     (start_rise)
  );

  // finished words wait here; a full fifo holds off the next start
  sac_word_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (fifo_ready),
    .out_valid (word_valid),
    .out_data  (word_data),
    .out_ready (word_ready)
  );

  // variant selection: only one of the two side inputs is ever looked at
  assign clear = ~FEED_FORWARD & master_clear;
  assign last  = (bit_q == '0) | (FEED_FORWARD & length_truncate);

  // a rise starts from anywhere; a held level restarts from cleared or done,
  // so with conv_done low only the cleared state stays put, while start is low or the fifo full
  always_comb begin
    go = start_rise;
    if ((state_q == sac_pkg::SAC_CLEARED) && start_conversion) begin
      go = 1'b1;
    end
    if ((state_q == sac_pkg::SAC_DONE) && start_conversion) begin
      go = 1'b1;
    end
    go = go & fifo_ready;
  end

  // next-state logic for the sequencer; all decisions are rising-edge samples
  always_comb begin
    state_d   = state_q;
    bit_d     = bit_q;
    result_d  = result_q;
    serial_d  = 1'b0;
    fin_d     = 1'b0;
    push      = 1'b0;
    push_data = result_q;
    if (clear) begin
      // outputs go to zero and stay there until a start is seen
      state_d  = sac_pkg::SAC_CLEARED;
      result_d = '0;
      serial_d = 1'b0;
    end else if (go) begin
      // first period: msb trial only, serial held off
      state_d  = sac_pkg::SAC_RUN;
      bit_d    = BW'(WIDTH - 1);
      result_d = {1'b1, {(WIDTH - 1){1'b0}}};
      serial_d = 1'b0;
    end else begin
      unique case (state_q)
        sac_pkg::SAC_CLEARED: begin
          result_d = '0;
        end
        sac_pkg::SAC_RUN: begin
          // the comparator sample itself decides the trial bit at this edge
          result_d[bit_q] = comp_decision;
          serial_d        = comp_decision;
          if (last) begin
            state_d   = sac_pkg::SAC_DONE;
            fin_d     = 1'b1;
            push      = 1'b1;
            push_data = result_d;
          end else begin
            bit_d                            = bit_q - BW'(1);
            result_d[BW'(bit_q - BW'(1))]    = 1'b1;
          end
        end
        sac_pkg::SAC_DONE: begin
          // decided bits hold; feed-forward keeps the last serial bit one more cycle
          result_d = result_q;
          serial_d = FEED_FORWARD & fin_q & serial_q;
        end
        default: begin
          state_d  = sac_pkg::SAC_CLEARED;
          result_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= sac_pkg::SAC_CLEARED;
      bit_q    <= '0;
      result_q <= '0;
      serial_q <= 1'b0;
      fin_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      bit_q    <= bit_d;
      result_q <= result_d;
      serial_q <= serial_d;
      fin_q    <= fin_d;
    end
  end

  // done follows the sequencer half a period late so the bits have settled
  always_comb begin
    done_d = (state_q == sac_pkg::SAC_DONE);
  end

  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  assign result_bits = result_q;
  assign serial_out  = serial_q;
  assign conv_done   = done_q;

endmodule

`default_nettype wire

// ### verilog/sac_defs.svh
// constants for the 8-bit successive approximation sequencer
// assumes inclusion by bare name from every design file that needs them
// Functional notes
// - every input is taken only on the rising clock edge; the code takes rst_n asynchronously
// - a sampled rise of start_conversion begins a conversion sequence
// - comparator decision is captured on a rising edge before it is used; the code writes comp_decision into the trial bit at that same edge
// - master_clear zeroes outputs; device stays cleared until start_conversion is high
// - length_truncate ends conversion early; held low for a full 8-bit word
// - each bit set high in turn MSB first, then kept or cleared by decision
// - a decided bit holds until clear or a new conversion
// - conv_done rises on the falling edge after the last decision or truncate
// - serial_out shows each decided bit, MSB first
// - serial_out is zero in first period, while cleared, second cycle after done
// - feed-forward releases serial one cycle after done; master-clear variant stays suppressed
// - with conv_done low and clock running no state is stable; the code rests in the cleared state while start_conversion is low
// - feed-forward variant restarts automatically after done while start_conversion is high
// - free-running and strobed operation, truncated or cascaded word lengths
// - one register converts at most eight bits; wider words need cascading
// - cascaded 12-bit converter updates results every thirteen clocks
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

`define SAC_WIDTH       8
`define SAC_FIFO_DEPTH  16
`define SAC_ST_CLEARED  3'h1
`define SAC_ST_RUN      3'h2
`define SAC_ST_DONE     3'h4

`endif

// ### verilog/sac_pkg.sv
// types shared by the approximation register files
// assumes sac_defs.svh is on the include path
`include "sac_defs.svh"

package sac_pkg;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    SAC_CLEARED = `SAC_ST_CLEARED,
    SAC_RUN     = `SAC_ST_RUN,
    SAC_DONE    = `SAC_ST_DONE
  } sac_state_t;

endpackage

// ### verilog/sac_rise_detect.sv
// rising-edge detector for a level that is synchronous to sys_clk
// assumes the input already meets setup to sys_clk
`timescale 1ns/1ps
`default_nettype none

module sac_rise_detect (
  input  wire logic sys_clk,  // system clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic level_in, // sampled level
  output logic      rise      // high in the cycle the level is first seen high
);

  logic prev_q;
  logic prev_d;

  // previous sample, taken on rising edges only
  always_comb begin
    prev_d = level_in;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = level_in & ~prev_q;

endmodule

`default_nettype wire

// ### verilog/sac_word_fifo.sv
// shift-register fifo for finished result words
// head entry is a flip-flop so the output needs no read mux
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_word_fifo #(
  parameter int WIDTH = `SAC_WIDTH,
  parameter int DEPTH = `SAC_FIFO_DEPTH
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire logic             in_valid,  // word offered
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  output logic                  in_ready,  // room for a word
  output logic                  out_valid, // head holds a word
  output logic      [WIDTH-1:0] out_data,  // head word
  input  wire logic             out_ready  // drain side takes the head
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             valid_q;
  logic             valid_d;
  logic             pop;
  logic             push;
  logic [CW-1:0]    wr_idx;

  // full is the honest count, so back-pressure reaches the sequencer
  assign in_ready = (count_q != CW'(DEPTH));
  assign pop      = valid_q & out_ready;
  assign push     = in_valid & in_ready;
  assign wr_idx   = count_q - CW'(pop);

  // occupancy and head valid
  always_comb begin
    count_d = count_q + CW'(push) - CW'(pop);
    valid_d = (count_d != '0);
  end

  // each entry shifts toward the head on pop; the write lands behind the last word
  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      mem_d[i] = mem_q[i];
      if (pop && (i < DEPTH - 1)) begin
        mem_d[i] = mem_q[(i < DEPTH - 1) ? i + 1 : i];
      end
      if (push && (wr_idx == CW'(i))) begin
        mem_d[i] = in_data;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      valid_q <= valid_d;
    end
  end

  assign out_valid = valid_q;
  assign out_data  = mem_q[0];

endmodule

`default_nettype wire
